// *** design/pdc_consts.svh ***
// Purpose: shared constants for the power-down controller and its cpu-side end
// Assumes: 8-bit control writes, one core clock
// Notes: timing and key values live here as macros
`ifndef PDC_CONSTS_SVH
`define PDC_CONSTS_SVH
`define PDC_SLEEP_KEY 8'h0f
`define PDC_STOP_KEY 8'h5a
`define PDC_CTRL_RESET 8'h00
`define PDC_BIT_START 8'h00
`define PDC_BIT_END 8'hff
`define PDC_PRESCALE_W 8
`define PDC_PRESCALE_RESET 8'h00
`define PDC_QUIET_NONE 2'h0
`define PDC_SLEEP_NOPS 2'h1
`define PDC_STOP_NOPS 2'h2
`endif

// *** design/pdc_pkg.sv ***
// Purpose: types used by the controller end of the power-down link
// Assumes: nothing beyond the constants header
// Notes: mode encoding
`default_nettype none
package pdc_pkg;
    // operating mode of the controller
    typedef enum logic [1:0] {MODE_RUN, MODE_SLEEP, MODE_STOP, MODE_STABLE} mode_t;
endpackage : pdc_pkg
`default_nettype wire

// *** design/pdc_if.sv ***
// Purpose: link between cpu core end and power-down controller
// Assumes: single core clock
// Notes: all signals are level or one-cycle strobes on core_clk
`default_nettype none
interface pdc_if;
    logic ctrl_wr; // one-cycle byte write strobe to control register
    logic [7:0] ctrl_wdata; // byte written
    logic halt_exec; // one-cycle strobe, halt instruction executed
    logic int_flag; // global interrupt enable flag of the cpu
    logic [7:0] prescale; // interval_timer_clock_control value
    logic cpu_stall; // cpu must not fetch or execute
    logic wake_vector; // one-cycle: take interrupt vector on resume
    logic wake_resume; // one-cycle: resume at next instruction
    logic [7:0] ctrl_rdata; // readback of sleep_stop_control_reg
    modport ctrl (input ctrl_wr, ctrl_wdata, halt_exec, int_flag, prescale,
                  output cpu_stall, wake_vector, wake_resume, ctrl_rdata);
    modport cpu (output ctrl_wr, ctrl_wdata, halt_exec, int_flag, prescale,
                 input cpu_stall, wake_vector, wake_resume, ctrl_rdata);
endinterface : pdc_if
`default_nettype wire

// *** design/power_down_controller.sv ***
// Purpose: sleep and stop mode control with stabilization count on wake-up
// Assumes: interrupt and event inputs are asynchronous pins, synchronised here
// Notes: clock gates are enables for an external clock gating cell
//        the controller itself stays clocked so it can see the wake pins
//        ram lives outside; nothing here touches it on any wake path
`include "pdc_consts.svh"
`default_nettype none
module power_down_controller #(
    parameter int PRESCALE_W = `PDC_PRESCALE_W
) (
    input wire logic core_clk,
    input wire logic nrst,
    pdc_if.ctrl link,
    input wire logic ext_int_pin,
    input wire logic periph_int_pin,
    input wire logic timer_two_event_input,
    input wire logic timer_three_event_input,
    output logic osc_run,
    output logic sys_clk_en,
    output logic periph_clk_en,
    output logic event_counter_en,
    output logic bit_run,
    output logic [1:0] mode_out
);
    // two-flop synchronisers for the four asynchronous wake pins
    // the first stage may settle late; only the second stage feeds logic
    // a pin pulse shorter than about one core cycle can be missed
    logic [3:0] wake_s1_q;
    logic [3:0] wake_s2_q;
    logic [3:0] wake_pins;
    assign wake_pins = {timer_three_event_input, timer_two_event_input,
                        periph_int_pin, ext_int_pin};
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wake_s1_q <= 4'h0;
            wake_s2_q <= 4'h0;
        end
        else
        begin
            wake_s1_q <= wake_pins;
            wake_s2_q <= wake_s1_q;
        end
    end

    // state of the controller
    pdc_pkg::mode_t mode_q, mode_d;
    logic [7:0] ctrl_q, ctrl_d; // sleep_stop_control_reg
    logic [7:0] bit_q, bit_d; // stabilization counter
    logic [PRESCALE_W-1:0] pre_q, pre_d; // prescaler dividing the counter
    logic vec_q, vec_d; // vectoring chosen at wake-up
    logic wv_q, wv_d; // wake vector strobe
    logic wr_q, wr_d; // wake resume strobe
    logic sleep_wake;
    logic stop_wake;

    // sleep ends on any interrupt; stop only on external or event pins
    // the peripheral interrupt cannot wake stop: its clock is off there
    // the event inputs count external edges, so they still see activity
    assign sleep_wake = wake_s2_q[0] | wake_s2_q[1];
    assign stop_wake = wake_s2_q[0] | wake_s2_q[2] | wake_s2_q[3];

    // next-state logic
    // defaults hold every register and drop both wake strobes
    always_comb
    begin
        mode_d = mode_q;
        ctrl_d = ctrl_q;
        bit_d = bit_q;
        pre_d = pre_q;
        vec_d = vec_q;
        wv_d = 1'b0;
        wr_d = 1'b0;
        unique case (mode_q)
            pdc_pkg::MODE_RUN:
            begin
                // only full-byte writes exist on this port
                // a write outranks a halt in the same cycle; the cpu end
                // never issues both, so the order only matters for misuse
                if (link.ctrl_wr)
                begin
                    ctrl_d = link.ctrl_wdata;
                    if (link.ctrl_wdata == `PDC_SLEEP_KEY)
                        mode_d = pdc_pkg::MODE_SLEEP;
                    // any other value stays in run mode
                end
                else if (link.halt_exec && ctrl_q == `PDC_STOP_KEY)
                    mode_d = pdc_pkg::MODE_STOP;
            end
            pdc_pkg::MODE_SLEEP:
            begin
                // the interrupt flag is captured at the wake event; a later
                // change does not alter the resume kind
                if (sleep_wake)
                begin
                    mode_d = pdc_pkg::MODE_STABLE;
                    vec_d = link.int_flag;
                    bit_d = `PDC_BIT_START;
                    pre_d = '0;
                    ctrl_d = `PDC_CTRL_RESET;
                end
            end
            pdc_pkg::MODE_STOP:
            begin
                // clocks frozen; registers and pc simply hold
                if (stop_wake)
                begin
                    mode_d = pdc_pkg::MODE_STABLE;
                    vec_d = link.int_flag;
                    bit_d = `PDC_BIT_START;
                    pre_d = '0;
                    ctrl_d = `PDC_CTRL_RESET;
                end
            end
            pdc_pkg::MODE_STABLE:
            begin
                // counter steps once per prescaler wrap; overflow releases cpu
                // the wait is 256 steps of prescale+1 cycles; software must not
                // move the prescaler meanwhile or the wait changes length
                if (pre_q == PRESCALE_W'(link.prescale))
                begin
                    pre_d = '0;
                    if (bit_q == `PDC_BIT_END)
                    begin
                        mode_d = pdc_pkg::MODE_RUN;
                        wv_d = vec_q;
                        wr_d = !vec_q;
                    end
                    else
                        bit_d = bit_q + 8'h01;
                end
                else
                    pre_d = pre_q + PRESCALE_W'(1);
            end
        endcase
    end

    // state registers; reset reinitialises control state, ram is elsewhere
    // an interrupt wake clears the key, restarts counter and prescaler and captures the vector choice
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mode_q <= pdc_pkg::MODE_RUN;
            ctrl_q <= `PDC_CTRL_RESET;
            bit_q <= `PDC_BIT_START;
            pre_q <= '0;
            vec_q <= 1'b0;
            wv_q <= 1'b0;
            wr_q <= 1'b0;
        end
        else
        begin
            mode_q <= mode_d;
            ctrl_q <= ctrl_d;
            bit_q <= bit_d;
            pre_q <= pre_d;
            vec_q <= vec_d;
            wv_q <= wv_d;
            wr_q <= wr_d;
        end
    end

    // registered outputs computed from the next state, so every output flop
    // moves on the same edge as the mode register and nothing lags a cycle
    logic osc_d, sys_d, per_d, evt_d, bitr_d, stall_d;
    always_comb
    begin
        osc_d = (mode_d != pdc_pkg::MODE_STOP);
        sys_d = (mode_d != pdc_pkg::MODE_STOP);
        per_d = (mode_d != pdc_pkg::MODE_STOP);
        evt_d = 1'b1; // event counters keep running in stop
        // interval timer runs in run, sleep and stabilising; stopped in stop
        bitr_d = (mode_d != pdc_pkg::MODE_STOP);
        stall_d = (mode_d != pdc_pkg::MODE_RUN);
    end

    // output flops; port drivers are left untouched so pins keep levels
    // the wake strobes stand one cycle; the cpu end copies them a cycle later
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            osc_run <= 1'b1;
            sys_clk_en <= 1'b1;
            periph_clk_en <= 1'b1;
            event_counter_en <= 1'b1;
            bit_run <= 1'b1;
            link.cpu_stall <= 1'b0;
            link.wake_vector <= 1'b0;
            link.wake_resume <= 1'b0;
            link.ctrl_rdata <= `PDC_CTRL_RESET;
            mode_out <= pdc_pkg::MODE_RUN;
        end
        else
        begin
            osc_run <= osc_d;
            sys_clk_en <= sys_d;
            periph_clk_en <= per_d;
            event_counter_en <= evt_d;
            bit_run <= bitr_d;
            link.cpu_stall <= stall_d;
            link.wake_vector <= wv_d;
            link.wake_resume <= wr_d;
            link.ctrl_rdata <= ctrl_d;
            mode_out <= mode_d;
        end
    end
endmodule : power_down_controller
`default_nettype wire

// *** design/cpu_power_end.sv ***
// Purpose: cpu-side end: turns core requests into link strobes
// Assumes: user side gives one-cycle requests
// Notes: refuses new requests while the controller stalls the cpu
`include "pdc_consts.svh"
`default_nettype none
module cpu_power_end (
    input wire logic core_clk,
    input wire logic nrst,
    pdc_if.cpu link,
    input wire logic req_sleep,
    input wire logic req_stop,
    input wire logic req_write,
    input wire logic [7:0] req_wdata,
    input wire logic gie,
    input wire logic [7:0] interval_timer_clock_control,
    output logic stalled,
    output logic take_vector,
    output logic resume_next
);
    // state of the stop sequence: key write then halt next cycle
    logic wr_q, wr_d;
    logic [7:0] wd_q, wd_d;
    logic halt_q, halt_d;
    logic stop_pend_q, stop_pend_d;
    logic [1:0] quiet_q, quiet_d; // cycles left in which no request is taken

    // sequencing: stop does key write, then halt; always full-byte
    always_comb
    begin
        wr_d = 1'b0;
        wd_d = wd_q;
        halt_d = 1'b0;
        stop_pend_d = 1'b0;
        // count down the quiet cycles that stand in for the entry nops
        quiet_d = (quiet_q != `PDC_QUIET_NONE) ? quiet_q - 2'h1 : `PDC_QUIET_NONE;
        if (stop_pend_q)
        begin
            halt_d = 1'b1; // halt right after the key load
            quiet_d = `PDC_STOP_NOPS;
        end
        // a request in the cycle before the stall shows would be lost
        else if (!link.cpu_stall && quiet_q == `PDC_QUIET_NONE)
        begin
            if (req_sleep)
            begin
                wr_d = 1'b1;
                wd_d = `PDC_SLEEP_KEY;
                quiet_d = `PDC_SLEEP_NOPS;
            end
            else if (req_stop)
            begin
                wr_d = 1'b1;
                wd_d = `PDC_STOP_KEY;
                stop_pend_d = 1'b1;
            end
            else if (req_write)
            begin
                wr_d = 1'b1;
                wd_d = req_wdata;
            end
        end
    end

    // registers; interrupt flag is passed so the controller can choose
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_q <= 1'b0;
            wd_q <= `PDC_CTRL_RESET;
            halt_q <= 1'b0;
            stop_pend_q <= 1'b0;
            quiet_q <= `PDC_QUIET_NONE;
            stalled <= 1'b0;
            take_vector <= 1'b0;
            resume_next <= 1'b0;
            link.int_flag <= 1'b0;
            link.prescale <= `PDC_PRESCALE_RESET;
        end
        else
        begin
            wr_q <= wr_d;
            wd_q <= wd_d;
            halt_q <= halt_d;
            stop_pend_q <= stop_pend_d;
            quiet_q <= quiet_d;
            stalled <= link.cpu_stall;
            take_vector <= link.wake_vector;
            resume_next <= link.wake_resume;
            link.int_flag <= gie;
            link.prescale <= interval_timer_clock_control;
        end
    end
    assign link.ctrl_wr = wr_q;
    assign link.ctrl_wdata = wd_q;
    assign link.halt_exec = halt_q;
endmodule : cpu_power_end
`default_nettype wire

// *** dv/pdc_link_chk.sv ***
// Purpose: assertions on the link between the cpu end and the controller
// Assumes: one core clock, nrst async low
// Notes: stall_q counts stalled cycles to bound stabilisation
`default_nettype none
module pdc_link_chk (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic ctrl_wr,
    input wire logic [7:0] ctrl_wdata,
    input wire logic halt_exec,
    input wire logic int_flag,
    input wire logic [7:0] prescale,
    input wire logic cpu_stall,
    input wire logic wake_vector,
    input wire logic wake_resume,
    input wire logic [7:0] ctrl_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    int stall_q; // cycles the cpu has been held
    int stall_d;
    // counter restarts whenever the cpu runs
    always_comb
    begin
        stall_d = cpu_stall ? stall_q + 1 : 0;
    end
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            stall_q <= 0;
        else
            stall_q <= stall_d;
    end
    AST_SLEEP_IN: assert property (
        ctrl_wr && ctrl_wdata == 8'h0f && !cpu_stall |=> cpu_stall) else $error("no sleep");
    AST_STOP_IN: assert property (
        halt_exec && ctrl_rdata == 8'h5a && !cpu_stall |=> cpu_stall) else $error("no stop");
    AST_OTHER_RUN: assert property (
        ctrl_wr && ctrl_wdata != 8'h0f && !halt_exec && !cpu_stall |=> !cpu_stall)
        else $error("write left run");
    AST_HALT_NOKEY: assert property (
        halt_exec && ctrl_rdata != 8'h5a && !ctrl_wr && !cpu_stall |=> !cpu_stall)
        else $error("halt without key stopped");
    AST_CLEARED: assert property (
        $fell(cpu_stall) |-> ctrl_rdata == 8'h00) else $error("control not cleared");
    AST_PULSE_AT_END: assert property (
        wake_vector || wake_resume |-> $fell(cpu_stall)) else $error("pulse off release");
    AST_VECTOR_SEL: assert property (
        $fell(cpu_stall) |-> wake_vector != wake_resume && wake_vector == int_flag)
        else $error("wrong resume kind");
    AST_ONE_CYCLE: assert property (
        wake_vector || wake_resume |=> !wake_vector && !wake_resume) else $error("long pulse");
    AST_STAB_LEN: assert property (
        $fell(cpu_stall) |-> stall_q >= 256 * (int'(prescale) + 1)) else $error("short wait");
    cover property (wake_vector);
    cover property (wake_resume);
    cover property (halt_exec && ctrl_rdata == 8'h5a);
endmodule : pdc_link_chk
`default_nettype wire

// *** dv/tb.sv ***
// Purpose: both ends joined by the link, driven from the cpu user side
// Assumes: step length zero, all wake pins async levels
// Notes: each scenario checks before it returns
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, nrst, ext_p, per_p, ev2, ev3, rs, rp, rw, gie, stalled;
    logic osc, sys, per, evc, bit_run;
    logic [1:0] mode;
    logic [7:0] wd;
    logic [7:0] itcc; // prescaler setting handed to the cpu end
    logic tv, rn; // vector and resume copies seen by the core
    localparam int STAB_STEPS = 256; // interval counter runs 00 to ff
    int miscompares = 0;
    int num_checks = 0;
    pdc_if bus ();
    power_down_controller i_power_down_controller (.core_clk(core_clk), .nrst(nrst),
        .link(bus), .ext_int_pin(ext_p), .periph_int_pin(per_p),
        .timer_two_event_input(ev2), .timer_three_event_input(ev3), .osc_run(osc),
        .sys_clk_en(sys), .periph_clk_en(per), .event_counter_en(evc), .bit_run(bit_run),
        .mode_out(mode));
    cpu_power_end i_cpu_power_end (.core_clk(core_clk), .nrst(nrst), .link(bus),
        .req_sleep(rs), .req_stop(rp), .req_write(rw), .req_wdata(wd), .gie(gie),
        .interval_timer_clock_control(itcc), .stalled(stalled), .take_vector(tv),
        .resume_next(rn));
    pdc_link_chk i_pdc_link_chk (.core_clk(core_clk), .nrst(nrst), .ctrl_wr(bus.ctrl_wr),
        .ctrl_wdata(bus.ctrl_wdata), .halt_exec(bus.halt_exec), .int_flag(bus.int_flag),
        .prescale(bus.prescale), .cpu_stall(bus.cpu_stall), .wake_vector(bus.wake_vector),
        .wake_resume(bus.wake_resume), .ctrl_rdata(bus.ctrl_rdata));
    // 8 ns core clock
    always #4 core_clk = ~core_clk;
    task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop
    // one-cycle user request: 0 sleep, 1 stop, 2 byte write
    task automatic req(input int k, input logic [7:0] d);
        @(posedge core_clk);
        rs <= (k == 0);
        rp <= (k == 1);
        rw <= (k == 2);
        wd <= d;
        @(posedge core_clk);
        {rs, rp, rw} <= 3'h0;
        repeat (4) @(posedge core_clk);
        #1;
    endtask : req
    // hold one wake pin high long enough to pass the synchroniser
    task automatic pin(input int p);
        @(posedge core_clk);
        {ev3, ev2, ext_p, per_p} <= 4'h1 << p;
        repeat (4) @(posedge core_clk);
        {ev3, ev2, ext_p, per_p} <= 4'h0;
    endtask : pin
    // wait for release, bounded well past the longest stabilisation
    task automatic wake(input logic g, input int pre);
        int n;
        n = 0;
        #1;
        chk("stab_mode", mode, pdc_pkg::MODE_STABLE);
        chk("stab_clk", {osc, sys, per, bit_run}, 4'hf);
        while (bus.cpu_stall === 1'b1 && n < 2000)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        // the loop starts one cycle after the counter does
        chk("stab", 16'(n), 16'(STAB_STEPS * (pre + 1) - 1));
        chk("vector", bus.wake_vector, g);
        chk("resume", bus.wake_resume, !g);
        chk("ctrl", bus.ctrl_rdata, 8'h00);
        chk("mode", mode, pdc_pkg::MODE_RUN);
        @(posedge core_clk);
        #1;
        chk("core_kind", {tv, rn}, {g, !g});
        chk("core_run", stalled, 0);
    endtask : wake
    task automatic t_sleep(input logic g, input logic [7:0] pre);
        @(posedge core_clk);
        gie <= g;
        itcc <= pre;
        req(0, 8'h00);
        chk("slp", mode, pdc_pkg::MODE_SLEEP);
        chk("stalled", stalled, 1);
        chk("clk", {osc, per, bit_run}, 3'h7);
        req(2, 8'h33);
        chk("keep", bus.ctrl_rdata, 8'h0f);
        pin(0);
        wake(g, int'(pre));
    endtask : t_sleep
    task automatic t_stop(input logic g, input int p);
        @(posedge core_clk);
        gie <= g;
        itcc <= 8'h00;
        req(1, 8'h00);
        chk("stp", mode, pdc_pkg::MODE_STOP);
        chk("clk", {osc, sys, per, bit_run}, 4'h0);
        chk("evc", evc, 1);
        pin(0);
        repeat (6) @(posedge core_clk);
        #1;
        chk("stay", mode, pdc_pkg::MODE_STOP);
        pin(p);
        wake(g, 0);
    endtask : t_stop
    // the stop key written alone, and another value, keep the cpu running
    task automatic t_keys();
        req(2, 8'h5a);
        chk("k5a", bus.cpu_stall, 0);
        req(2, 8'h33);
        chk("k33", bus.cpu_stall, 0);
        chk("rd", bus.ctrl_rdata, 8'h33);
    endtask : t_keys
    // reset in mid-sleep reinitialises control state, then the block runs again
    task automatic t_reset();
        req(0, 8'h00);
        @(posedge core_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        #1;
        chk("rst", {bus.cpu_stall, mode}, 3'h0);
        chk("rrd", bus.ctrl_rdata, 8'h00);
        req(2, 8'h33);
        chk("rrun", bus.ctrl_rdata, 8'h33);
    endtask : t_reset
    initial
    begin
        {core_clk, nrst, ext_p, per_p, ev2, ev3, rs, rp, rw, gie} = 10'h000;
        wd = 8'h00;
        itcc = 8'h00;
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        t_keys();
        t_sleep(1, 8'h00);
        t_sleep(0, 8'h01);
        for (int p = 1; p < 4; p++)
            t_stop(p[0], p);
        t_reset();
        report_and_stop();
    end
    // hang guard, far above the expected run
    initial
    begin
        #200000;
        miscompares++;
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
